// >>> hdl/tmcs_sequencer.sv
//Contract
//[RULE_01] codes 07 and 03 both start a rewind
//[RULE_02] both rewinds run the same sequence
//[RULE_03] host selects unit then writes command
//[RULE_04] drive select bits onto slave bus
//[RULE_05] rewind line; off-line adds record enable
//[RULE_06] rewind: launch plus halt, then clear active
//[RULE_07] transport starts rewind on launch pulse
//[RULE_08] transport returns to marker and stops
//[RULE_09] status change sets attention and host line
//[RULE_10] host loads negative count, writes space code
//[RULE_11] space: direction line, launch, delay enable; code raises delay enable with the direction line, a cycle before launch
//[RULE_12] delay built from transport presets
//[RULE_13] spacing detects characters, inhibits assembly
//[RULE_14] each gap: count, delay, halt, relaunch
//[RULE_15] halt to relaunch well under one microsecond
//[RULE_16] count overflow withholds next launch
//[RULE_17] markers or overflow end spacing, clear active
//[RULE_18] erase: forward plus record enable, launch
//[RULE_19] transport energises heads on launch
//[RULE_20] preset counts up; two means at speed
//[RULE_21] erase stop delay then halt, clear active
//[RULE_22] transport drops motion on halt
//[RULE_23] frame count writes only while idle
//[RULE_24] space without loaded count is illegal
//[RULE_25] commands written while active are ignored
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tmcs_regs.svh"

module tmcs_sequencer
    import tmcs_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output var  logic [31:0]     prdata,
    output var  logic            pready,
    output var  logic            pslverr,
    input  wire tmcs_slave_in_t  slaveIn,
    output var  tmcs_slave_out_t slaveOut,
    output var  logic            hostAttentionLine
);

    tmcs_state_t state_q;
    logic [5:0]  code_q;
    logic [2:0]  select_q;
    logic [15:0] frameCount_q;
    logic [7:0]  delay_q;
    logic        countLoaded_q;
    logic        attention_q;
    logic        illegalFn_q;
    logic        isErase_q;
    logic        rewindLine_q;
    logic        aheadLine_q;
    logic        backLine_q;
    logic        recEnLine_q;
    logic        launch_q;
    logic        halt_q;
    logic        delayEn_q;

    logic        access;
    logic        wrDone;
    logic [3:0]  regIdx;
    logic        idxOk;
    logic        active;
    logic        cmdWrite;
    logic [5:0]  newCode;
    logic        isRewind;
    logic        isSpace;
    logic        isEraseCode;
    logic        cmdIllegal;
    logic        delayDone;
    logic        marker;
    logic        gapCount;

    assign access   = psel & penable;
    assign wrDone   = access & pready & pwrite;
    assign regIdx   = paddr[5:2];
    assign idxOk    = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
                      (regIdx == `TMCS_IDX_COMMAND || regIdx == `TMCS_IDX_STATUS ||
                       regIdx == `TMCS_IDX_FRAME_COUNT || regIdx == `TMCS_IDX_SELECT);
    assign active   = (state_q != TMCS_IDLE);
    assign cmdWrite = wrDone && idxOk && regIdx == `TMCS_IDX_COMMAND;
    assign newCode  = pwdata[`TMCS_CMD_CODE_MSB:0];

    assign isRewind    = (newCode == `TMCS_FN_REWIND_ONLINE) ||
                         (newCode == `TMCS_FN_REWIND_OFFLINE); // RULE_01
    assign isSpace     = (newCode == `TMCS_FN_SPACE_FWD) || (newCode == `TMCS_FN_SPACE_REV);
    assign isEraseCode = (newCode == `TMCS_FN_ERASE);
    // unknown codes, and spacing without a loaded count, are refused
    assign cmdIllegal  = (isSpace && !countLoaded_q) || // RULE_24
                         !(isRewind || isSpace || isEraseCode);

    assign delayDone = (delay_q == `TMCS_DELAY_DONE); // RULE_20
    assign marker    = slaveIn.tapeStartMarker | slaveIn.tapeEndMarker | slaveIn.fileMarkSeen;
    assign gapCount  = (state_q == TMCS_SP_READ) && !marker && slaveIn.interrecordGap;

    // apb: one wait state, so every answer comes from a flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready  <= 1'b1;
            pslverr <= !idxOk;
            prdata  <= 32'h0000_0000;
            if (idxOk && !pwrite) begin
                unique case (regIdx)
                    `TMCS_IDX_COMMAND: prdata <= {26'h0, code_q[5:1], active};
                    `TMCS_IDX_STATUS: prdata <= {28'h0, active, countLoaded_q,
                                                 illegalFn_q, attention_q};
                    `TMCS_IDX_FRAME_COUNT: prdata <= {16'h0, frameCount_q};
                    default: prdata <= {29'h0, select_q};
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // unit select; held steady while a command runs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            select_q <= `TMCS_RST_SELECT;
        end else if (wrDone && idxOk && regIdx == `TMCS_IDX_SELECT && !active) begin
            select_q <= pwdata[`TMCS_SEL_MSB:0]; // RULE_03
        end
    end

    // frame counter and its loaded flag
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frameCount_q  <= `TMCS_RST_FRAME_COUNT;
            countLoaded_q <= 1'b0;
        end else if (gapCount) begin
            frameCount_q <= frameCount_q + 16'h0001; // RULE_14
            if (frameCount_q == 16'hffff) begin
                countLoaded_q <= 1'b0;
            end
        end else if (wrDone && idxOk && regIdx == `TMCS_IDX_FRAME_COUNT && !active) begin
            frameCount_q  <= pwdata[15:0]; // RULE_23
            countLoaded_q <= 1'b1;
        end
    end

    // sticky status; a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            attention_q <= 1'b0;
            illegalFn_q <= 1'b0;
        end else begin
            if (wrDone && idxOk && regIdx == `TMCS_IDX_STATUS) begin
                if (pwdata[`TMCS_ST_ATTENTION]) begin
                    attention_q <= 1'b0;
                end
                if (pwdata[`TMCS_ST_ILLEGAL_FN]) begin
                    illegalFn_q <= 1'b0;
                end
            end
            if (slaveIn.transportStatusChange) begin
                attention_q <= 1'b1; // RULE_09
            end
            if (cmdWrite && !active && cmdIllegal) begin
                illegalFn_q <= 1'b1; // RULE_24
            end
        end
    end

    // motion delay: preset loaded, then counted up each cycle
    // limitation: no prescale, so the transport presets set the full length
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_q <= 8'h00;
        end else if (state_q == TMCS_LOAD || state_q == TMCS_SP_GAPLD ||
                     state_q == TMCS_ER_STOPLD) begin
            delay_q <= slaveIn.readData; // RULE_12
        end else if (!delayDone) begin
            delay_q <= delay_q + 8'h01; // RULE_20
        end
    end

    // sequencer with its slave-bus lines
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= TMCS_IDLE;
            code_q       <= `TMCS_RST_CODE;
            isErase_q    <= 1'b0;
            rewindLine_q <= 1'b0;
            aheadLine_q  <= 1'b0;
            backLine_q   <= 1'b0;
            recEnLine_q  <= 1'b0;
            launch_q     <= 1'b0;
            halt_q       <= 1'b0;
            delayEn_q    <= 1'b0;
        end else begin
            launch_q <= 1'b0;
            halt_q   <= 1'b0;
            unique case (state_q)
                TMCS_IDLE: begin
                    // a command written while busy never reaches here
                    if (cmdWrite && !cmdIllegal) begin // RULE_25
                        code_q    <= newCode;
                        isErase_q <= isEraseCode;
                        if (isRewind) begin
                            rewindLine_q <= 1'b1; // RULE_05
                            recEnLine_q  <= (newCode == `TMCS_FN_REWIND_OFFLINE); // RULE_05
                            state_q      <= TMCS_REW_GO; // RULE_02
                        end else if (isSpace) begin
                            aheadLine_q <= (newCode == `TMCS_FN_SPACE_FWD); // RULE_11
                            backLine_q  <= (newCode == `TMCS_FN_SPACE_REV); // RULE_11
                            // enable leads launch so presets stand when load samples them
                            delayEn_q   <= 1'b1; // RULE_12
                            state_q     <= TMCS_LAUNCH;
                        end else begin
                            aheadLine_q <= 1'b1; // RULE_18
                            recEnLine_q <= 1'b1; // RULE_18
                            delayEn_q   <= 1'b1; // RULE_12
                            state_q     <= TMCS_LAUNCH;
                        end
                    end
                end
                TMCS_REW_GO: begin
                    launch_q <= 1'b1; // RULE_06
                    halt_q   <= 1'b1; // RULE_06
                    state_q  <= TMCS_FINISH;
                end
                TMCS_LAUNCH: begin
                    launch_q  <= 1'b1; // RULE_11
                    delayEn_q <= 1'b1; // RULE_18
                    state_q   <= TMCS_LOAD;
                end
                TMCS_LOAD: begin
                    state_q <= isErase_q ? TMCS_ER_START : TMCS_SP_START;
                end
                TMCS_SP_START: begin
                    if (marker) begin
                        halt_q  <= 1'b1; // RULE_17
                        state_q <= TMCS_FINISH;
                    end else if (delayDone) begin
                        state_q <= TMCS_SP_READ;
                    end
                end
                TMCS_SP_READ: begin
                    if (marker) begin
                        halt_q  <= 1'b1; // RULE_17
                        state_q <= TMCS_FINISH;
                    end else if (slaveIn.interrecordGap) begin
                        state_q <= TMCS_SP_GAPLD; // RULE_14
                    end
                end
                TMCS_SP_GAPLD: begin
                    state_q <= TMCS_SP_GAP;
                end
                TMCS_SP_GAP: begin
                    if (marker) begin
                        halt_q  <= 1'b1; // RULE_17
                        state_q <= TMCS_FINISH;
                    end else if (delayDone) begin
                        halt_q <= 1'b1; // RULE_14
                        if (frameCount_q == 16'h0000) begin
                            state_q <= TMCS_FINISH; // RULE_16
                        end else begin
                            state_q <= TMCS_SP_RELAUNCH;
                        end
                    end
                end
                TMCS_SP_RELAUNCH: begin
                    // one cycle after halt keeps the hand-off far inside a microsecond
                    launch_q <= 1'b1; // RULE_15
                    state_q  <= TMCS_LOAD; // RULE_14
                end
                TMCS_ER_START: begin
                    if (delayDone) begin
                        state_q <= TMCS_ER_STOPLD;
                    end
                end
                TMCS_ER_STOPLD: begin
                    state_q <= TMCS_ER_STOP;
                end
                TMCS_ER_STOP: begin
                    if (delayDone) begin
                        halt_q  <= 1'b1; // RULE_21
                        state_q <= TMCS_FINISH;
                    end
                end
                TMCS_FINISH: begin
                    rewindLine_q <= 1'b0;
                    aheadLine_q  <= 1'b0;
                    backLine_q   <= 1'b0;
                    recEnLine_q  <= 1'b0;
                    delayEn_q    <= 1'b0;
                    state_q      <= TMCS_IDLE; // RULE_17
                end
            endcase
        end
    end

    // all outputs come straight from flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slaveOut          <= '0;
            hostAttentionLine <= 1'b0;
        end else begin
            slaveOut.unitSelect          <= select_q; // RULE_04
            slaveOut.rewindRequestLine   <= rewindLine_q;
            slaveOut.aheadMotionLine     <= aheadLine_q;
            slaveOut.backwardMotionLine  <= backLine_q;
            slaveOut.recordEnableLine    <= recEnLine_q;
            slaveOut.launchPulse         <= launch_q;
            slaveOut.haltLine            <= halt_q;
            slaveOut.motionDelayEnable   <= delayEn_q;
            slaveOut.charAssemblyInhibit <= aheadLine_q | backLine_q; // RULE_13
            hostAttentionLine            <= attention_q; // RULE_09
        end
    end

endmodule : tmcs_sequencer
`default_nettype wire

// >>> inc/tmcs_regs.svh
`ifndef TMCS_REGS_SVH
`define TMCS_REGS_SVH

// register indices; byte address is four times the index
`define TMCS_IDX_COMMAND       4'h0
`define TMCS_IDX_STATUS        4'h1
`define TMCS_IDX_FRAME_COUNT   4'h5
`define TMCS_IDX_SELECT        4'h9

// command register fields
`define TMCS_CMD_CODE_MSB      5
`define TMCS_CMD_GO_BIT        0

// function codes, go bit included
`define TMCS_FN_REWIND_ONLINE  6'h07
`define TMCS_FN_REWIND_OFFLINE 6'h03
`define TMCS_FN_SPACE_FWD      6'h19
`define TMCS_FN_SPACE_REV      6'h1b
`define TMCS_FN_ERASE          6'h15

// status register bits, write one to clear the sticky ones
`define TMCS_ST_ATTENTION      0
`define TMCS_ST_ILLEGAL_FN     1
`define TMCS_ST_COUNT_LOADED   2
`define TMCS_ST_ACTIVE         3

// transport select field
`define TMCS_SEL_MSB           2

// reset values
`define TMCS_RST_FRAME_COUNT   16'h0000
`define TMCS_RST_SELECT        3'h0
`define TMCS_RST_CODE          6'h00

// motion delay counter reaches speed at this count
`define TMCS_DELAY_DONE        8'h02

`endif

// >>> inc/tmcs_pkg.sv
`default_nettype none
package tmcs_pkg;

    typedef enum logic [3:0] {
        TMCS_IDLE,
        TMCS_REW_GO,
        TMCS_LAUNCH,
        TMCS_LOAD,
        TMCS_SP_START,
        TMCS_SP_READ,
        TMCS_SP_GAPLD,
        TMCS_SP_GAP,
        TMCS_SP_RELAUNCH,
        TMCS_ER_START,
        TMCS_ER_STOPLD,
        TMCS_ER_STOP,
        TMCS_FINISH
    } tmcs_state_t;

    // lines driven toward the selected transport
    typedef struct packed {
        logic [2:0] unitSelect;
        logic       rewindRequestLine;
        logic       aheadMotionLine;
        logic       backwardMotionLine;
        logic       recordEnableLine;
        logic       launchPulse;
        logic       haltLine;
        logic       motionDelayEnable;
        logic       charAssemblyInhibit;
    } tmcs_slave_out_t;

    // lines returned by the transport
    typedef struct packed {
        logic [7:0] readData;
        logic       transportStatusChange;
        logic       tapeStartMarker;
        logic       tapeEndMarker;
        logic       fileMarkSeen;
        logic       interrecordGap;
    } tmcs_slave_in_t;

endpackage : tmcs_pkg
`default_nettype wire

// >>> sim/tmcs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tmcs_properties
    import tmcs_pkg::*;
(
    input wire logic            sys_clk,
    input wire logic            rst_n,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic            pready,
    input wire tmcs_slave_in_t  slaveIn,
    input wire tmcs_slave_out_t slaveOut,
    input wire logic            hostAttentionLine
);
    logic mv;
    assign mv = slaveOut.aheadMotionLine | slaveOut.backwardMotionLine;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_rew_go;
        $rose(slaveOut.rewindRequestLine) |-> ##1 (slaveOut.launchPulse && slaveOut.haltLine);
    endproperty
    a_rew_go: assert property (p_rew_go) else $error("rewind launch missing");
    property p_mv_go;
        $rose(mv) |-> ##1 (slaveOut.launchPulse && slaveOut.motionDelayEnable);
    endproperty
    a_mv_go: assert property (p_mv_go) else $error("motion launch missing");
    property p_launch_why;
        slaveOut.launchPulse |-> (mv || slaveOut.rewindRequestLine);
    endproperty
    a_launch_why: assert property (p_launch_why) else $error("launch without command");
    property p_rec_en;
        slaveOut.recordEnableLine |-> !slaveOut.backwardMotionLine
            && (slaveOut.rewindRequestLine || slaveOut.aheadMotionLine);
    endproperty
    a_rec_en: assert property (p_rec_en) else $error("record enable misplaced");
    property p_inhibit;
        slaveOut.charAssemblyInhibit == mv;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("assembly inhibit wrong");
    property p_attn;
        slaveIn.transportStatusChange |-> ##2 hostAttentionLine;
    endproperty
    a_attn: assert property (p_attn) else $error("attention not raised");
    property p_sel;
        psel && penable && pready && pwrite && paddr == 8'h24 && !mv
            && !slaveOut.rewindRequestLine |=> ##1 slaveOut.unitSelect == $past(pwdata[2:0], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("unit select not driven");
    property p_ready;
        pready |=> !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready longer than one cycle");
endmodule : tmcs_properties
bind tmcs_sequencer tmcs_properties tmcs_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .slaveIn(slaveIn), .slaveOut(slaveOut),
    .hostAttentionLine(hostAttentionLine));
`default_nettype wire

// >>> sim/tmcs_transport_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmcs_transport_model
    import tmcs_pkg::*;
#(
    parameter logic [7:0] PRESET = 8'hfc,
    parameter int         GAPN   = 12,
    parameter int         REWN   = 30
)(
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire tmcs_slave_out_t slaveOut,
    input  wire logic            markReq,
    output var  tmcs_slave_in_t  slaveIn
);
    logic       moving;
    logic [7:0] lastRd;
    int         gapCnt;
    int         rewCnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            moving <= 1'b0;
            gapCnt <= 0;
            rewCnt <= 0;
            lastRd <= 8'h00;
        end else begin
            if (slaveOut.launchPulse && !slaveOut.rewindRequestLine) begin
                moving <= 1'b1;
                gapCnt <= 0;
            end else if (slaveOut.haltLine) begin
                moving <= 1'b0;
            end else if (moving) begin
                gapCnt <= gapCnt + 1;
            end
            if (slaveOut.launchPulse && slaveOut.rewindRequestLine) begin
                rewCnt <= REWN;
            end else if (rewCnt != 0) begin
                rewCnt <= rewCnt - 1;
            end
            lastRd <= slaveIn.readData;
        end
    end
    always_comb begin
        // released data lines toggle so stale values never look valid
        slaveIn.readData = slaveOut.motionDelayEnable ? PRESET : ~lastRd;
        slaveIn.transportStatusChange = (rewCnt == 1);
        slaveIn.tapeStartMarker = 1'b0;
        slaveIn.tapeEndMarker = markReq && moving;
        slaveIn.fileMarkSeen = 1'b0;
        slaveIn.interrecordGap = moving && !slaveOut.recordEnableLine && gapCnt == GAPN - 1;
    end
endmodule : tmcs_transport_model
`default_nettype wire

// >>> sim/tmcs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tmcs_sequencer_tb
    import tmcs_pkg::*;
;
    logic            sys_clk, rst_n, psel, penable, pwrite, markReq, errSeen;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            pready, pslverr, hostAttentionLine;
    tmcs_slave_in_t  slaveIn;
    tmcs_slave_out_t slaveOut;
    int              err_total = 0, n_compared = 0, cyc = 0;
    int              nLaunch = 0, nHalt = 0, nRec = 0, nRev = 0, l0, h0, r0, v0;
    tmcs_sequencer tmcs_sequencer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slaveIn(slaveIn), .slaveOut(slaveOut),
        .hostAttentionLine(hostAttentionLine));
    tmcs_transport_model #(.PRESET(8'hfc), .GAPN(12), .REWN(30)) tmcs_transport_model_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .slaveOut(slaveOut), .markReq(markReq),
        .slaveIn(slaveIn));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        nLaunch <= nLaunch + int'(slaveOut.launchPulse);
        nHalt <= nHalt + int'(slaveOut.haltLine);
        nRec <= nRec + int'(slaveOut.launchPulse && slaveOut.recordEnableLine);
        nRev <= nRev + int'(slaveOut.launchPulse && slaveOut.backwardMotionLine);
        if (cyc == 30000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        errSeen = pslverr;
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0);
            n++;
        end while (rd[3] !== 1'b0 && n < 500);
        chk("went idle", 32'h0, {31'h0, rd[3]});
    endtask : wait_idle
    task automatic snap();
        l0 = nLaunch;
        h0 = nHalt;
        r0 = nRec;
        v0 = nRev;
    endtask : snap
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    initial begin
        logic [7:0] addrs [4] = '{8'h00, 8'h04, 8'h14, 8'h24};
        logic [5:0] rw [2] = '{6'h07, 6'h03};
        int n;
        {rst_n, psel, penable, pwrite, markReq, paddr, pwdata} = '0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (addrs[i]) begin
            apb(1'b0, addrs[i], 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, errSeen});
        apb(1'b1, 8'h24, 32'h5);
        @(posedge sys_clk);
        chk("unit select", 32'h5, {29'h0, slaveOut.unitSelect});
        snap();
        apb(1'b1, 8'h00, 32'h19);
        apb(1'b0, 8'h04, 32'h0);
        chk("illegal status", 32'h2, rd);
        chk("no launch", 32'h0, 32'(nLaunch - l0));
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b0, 8'h04, 32'h0);
        chk("status cleared", 32'h0, rd);
        // three records, then writes that must bounce off the busy sequencer
        apb(1'b1, 8'h14, 32'hfffd);
        snap();
        apb(1'b1, 8'h00, 32'h19);
        apb(1'b1, 8'h14, 32'h1234);
        apb(1'b1, 8'h00, 32'h07);
        wait_idle();
        apb(1'b0, 8'h14, 32'h0);
        chk("count overflow", 32'h0, rd);
        chk("space launches", 32'h3, 32'(nLaunch - l0));
        chk("space halts", 32'h3, 32'(nHalt - h0));
        apb(1'b0, 8'h04, 32'h0);
        chk("space status", 32'h0, rd);
        apb(1'b1, 8'h14, 32'hfff0);
        snap();
        markReq <= 1'b1;
        apb(1'b1, 8'h00, 32'h1b);
        wait_idle();
        markReq <= 1'b0;
        apb(1'b0, 8'h14, 32'h0);
        chk("marker count", 32'hfff0, rd);
        chk("reverse launch", 32'h1, 32'(nRev - v0));
        chk("marker halt", 32'h1, 32'(nHalt - h0));
        snap();
        apb(1'b1, 8'h00, 32'h15);
        wait_idle();
        chk("erase launch", 32'h1, 32'(nRec - r0));
        chk("erase halt", 32'h1, 32'(nHalt - h0));
        foreach (rw[i]) begin
            snap();
            apb(1'b1, 8'h00, {26'h0, rw[i]});
            wait_idle();
            chk("rewind launch", 32'h1, 32'(nLaunch - l0));
            chk("rewind halt", 32'h1, 32'(nHalt - h0));
            chk("offline enable", 32'(rw[i] == 6'h03), 32'(nRec - r0));
            n = 0;
            while (hostAttentionLine !== 1'b1 && n < 200) begin
                @(posedge sys_clk);
                n++;
            end
            apb(1'b0, 8'h04, 32'h0);
            // count stays loaded: the marker stop never overflowed the frame counter
            chk("attention", 32'h5, rd);
            apb(1'b1, 8'h04, 32'h1);
            apb(1'b0, 8'h04, 32'h0);
            chk("attention clear", 32'h4, rd);
        end
        complete_run();
    end
endmodule : tmcs_sequencer_tb
`default_nettype wire
